// ### serial_port_pkg.sv
// Package with register map, field positions and constants of the serial port.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package serial_port_pkg;
  localparam logic [7:0] ADDR_DATA    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h0B;
  localparam logic [7:0] ADDR_CONTROL = 8'h0A;
  localparam logic [7:0] ADDR_DIVISOR = 8'h09;
  localparam logic [7:0] CONTROL_RESET = 8'h02;
  localparam logic [7:0] STATUS_RESET  = 8'h20;
  localparam int BIT_RX_DONE   = 7;
  localparam int BIT_TX_DONE   = 6;
  localparam int BIT_TX_EMPTY  = 5;
  localparam int BIT_FRAME_ERR = 4;
  localparam int BIT_OVERRUN   = 3;
  localparam int BIT_RX_IE     = 7;
  localparam int BIT_TX_IE     = 6;
  localparam int BIT_EMPTY_IE  = 5;
  localparam int BIT_RX_ON     = 4;
  localparam int BIT_TX_ON     = 3;
  localparam int BIT_NINE      = 2;
  localparam int BIT_RX_NINTH  = 1;
  localparam int BIT_TX_NINTH  = 0;
  localparam logic [3:0] SAMPLE_A   = 4'h7;
  localparam logic [3:0] SAMPLE_B   = 4'h8;
  localparam logic [3:0] SAMPLE_C   = 4'h9;
  localparam logic [3:0] SAMPLE_END = 4'hF;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;
endpackage : serial_port_pkg

// ### baud_tick_if.sv
// Interface carrying the oversampling tick and divisor between modules.
`timescale 1ns/1ps
interface baud_tick_if;
  logic [7:0] divisor;
  logic       tick;
  modport gen  (input divisor, output tick);
  modport user (output divisor, input tick);
endinterface : baud_tick_if

// ### baud_tick_gen.sv
// Oversampling tick generator for the serial port.
`timescale 1ns/1ps
module baud_tick_gen (
  input  wire logic    i_clk,
  input  wire logic    i_nrst,
  input  wire logic    i_en,
  baud_tick_if.gen     bt
);
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       tick_q;
  logic       tick_d;

  always_comb begin
    count_d = count_q;
    tick_d  = 1'b0;
    if (count_q == 8'h00) begin
      count_d = bt.divisor;
      tick_d  = 1'b1;
    end else begin
      count_d = count_q - 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_q <= 8'h00;
      tick_q  <= 1'b0;
    end else if (i_en) begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  assign bt.tick = tick_q & i_en;
endmodule : baud_tick_gen

// ### serial_port.sv
// Full-duplex serial port with status, control and baud divider registers.
`timescale 1ns/1ps
module serial_port
  import serial_port_pkg::*;
(
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_NRST,
  input  wire logic       I_CLK_EN,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic       I_TX_DONE_ACK,
  input  wire logic       I_RXD,
  output logic      [7:0] O_RDATA,
  output logic            O_TXD,
  output logic            O_TXD_OE,
  output logic            O_RX_DONE_IRQ,
  output logic            O_TX_DONE_IRQ,
  output logic            O_TX_EMPTY_IRQ
);

  //----------------------------------------------------------------------------
  // Tick generator
  //----------------------------------------------------------------------------
  baud_tick_if bt ();
  logic [7:0] divisor_q;
  logic [7:0] divisor_d;
  assign bt.divisor = divisor_q;

  baud_tick_gen u_tick (
    .i_clk  (I_CORE_CLK),
    .i_nrst (I_NRST),
    .i_en   (I_CLK_EN),
    .bt     (bt)
  );

  //----------------------------------------------------------------------------
  // Receive pin synchroniser
  //----------------------------------------------------------------------------
  logic [2:0] rx_sync_q;
  logic       rx_line_q;
  logic       rx_line_d;

  always_comb begin
    rx_line_d = rx_line_q;
    if (rx_sync_q[1] == rx_sync_q[2]) begin
      rx_line_d = rx_sync_q[2];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rx_sync_q <= 3'h7;
      rx_line_q <= 1'b1;
    end else if (I_CLK_EN) begin
      rx_sync_q <= {rx_sync_q[1:0], I_RXD};
      rx_line_q <= rx_line_d;
    end
  end

  //----------------------------------------------------------------------------
  // Register state
  //----------------------------------------------------------------------------
  logic       wr_data;
  logic       rd_data;
  logic       wr_status;
  logic       wr_control;
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic [7:0] tx_hold_q;
  logic [7:0] tx_hold_d;
  logic       tx_pending_q;
  logic       tx_pending_d;
  logic [7:0] rx_data_q;
  logic [7:0] rx_data_d;
  logic       rx_done_flag_q;
  logic       rx_done_flag_d;
  logic       tx_done_flag_q;
  logic       tx_done_flag_d;
  logic       tx_buffer_empty_flag_q;
  logic       tx_buffer_empty_flag_d;
  logic       framing_error_flag_q;
  logic       framing_error_flag_d;
  logic       overrun_flag_q;
  logic       overrun_flag_d;
  logic       overrun_hidden_q;
  logic       overrun_hidden_d;
  logic [7:0] rdata_d;

  assign wr_data    = I_WR && (I_ADDR == ADDR_DATA);
  assign rd_data    = I_RD && (I_ADDR == ADDR_DATA);
  assign wr_status  = I_WR && (I_ADDR == ADDR_STATUS);
  assign wr_control = I_WR && (I_ADDR == ADDR_CONTROL);

  //----------------------------------------------------------------------------
  // Transmitter
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_t;

  tx_state_t  tx_state_q;
  tx_state_t  tx_state_d;
  logic [10:0] tx_shift_q;
  logic [10:0] tx_shift_d;
  logic [3:0] tx_bits_q;
  logic [3:0] tx_bits_d;
  logic [3:0] tx_phase_q;
  logic [3:0] tx_phase_d;
  logic       txd_d;
  logic       txd_oe_d;
  logic       tx_load;
  logic       tx_finish;

  always_comb begin
    tx_state_d = tx_state_q;
    tx_shift_d = tx_shift_q;
    tx_bits_d  = tx_bits_q;
    tx_phase_d = tx_phase_q;
    tx_load    = 1'b0;
    tx_finish  = 1'b0;
    unique case (tx_state_q)
      TX_IDLE: begin
        // Pending data goes out even after the enable drops.
        if (tx_pending_q) begin
          tx_load    = 1'b1;
          tx_state_d = TX_SHIFT;
          tx_phase_d = 4'h0;
          // Start low, data LSB first, stop high.
          if (control_q[BIT_NINE]) begin
            tx_shift_d = {1'b1, control_q[BIT_TX_NINTH], tx_hold_q, 1'b0};
            tx_bits_d  = BITS_NINE + 4'h2;
          end else begin
            tx_shift_d = {2'b11, tx_hold_q, 1'b0};
            tx_bits_d  = BITS_EIGHT + 4'h2;
          end
        end
      end
      TX_SHIFT: begin
        if (bt.tick) begin
          tx_phase_d = tx_phase_q + 4'h1;
          if (tx_phase_q == SAMPLE_END) begin
            tx_shift_d = {1'b1, tx_shift_q[10:1]};
            tx_bits_d  = tx_bits_q - 4'h1;
            if (tx_bits_q == 4'h1) begin
              tx_state_d = TX_IDLE;
              tx_finish  = !tx_pending_q;
            end
          end
        end
      end
      default: tx_state_d = TX_IDLE;
    endcase
    txd_d    = (tx_state_d == TX_SHIFT) ? tx_shift_d[0] : 1'b1;
    txd_oe_d = control_q[BIT_TX_ON] || (tx_state_d == TX_SHIFT) || tx_pending_d;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 11'h7FF;
      tx_bits_q  <= 4'h0;
      tx_phase_q <= 4'h0;
      O_TXD      <= 1'b1;
      O_TXD_OE   <= 1'b0;
    end else if (I_CLK_EN) begin
      tx_state_q <= tx_state_d;
      tx_shift_q <= tx_shift_d;
      tx_bits_q  <= tx_bits_d;
      tx_phase_q <= tx_phase_d;
      O_TXD      <= txd_d;
      O_TXD_OE   <= txd_oe_d;
    end
  end

  //----------------------------------------------------------------------------
  // Receiver
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } rx_state_t;

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority

  rx_state_t  rx_state_q;
  rx_state_t  rx_state_d;
  logic [3:0] rx_phase_q;
  logic [3:0] rx_phase_d;
  logic [2:0] rx_samp_q;
  logic [2:0] rx_samp_d;
  logic [3:0] rx_bits_q;
  logic [3:0] rx_bits_d;
  logic [8:0] rx_shift_q;
  logic [8:0] rx_shift_d;
  logic       rx_bit;
  logic       rx_end;
  logic       rx_stop_ok;

  always_comb begin
    rx_state_d = rx_state_q;
    rx_phase_d = rx_phase_q;
    rx_samp_d  = rx_samp_q;
    rx_bits_d  = rx_bits_q;
    rx_shift_d = rx_shift_q;
    rx_end     = 1'b0;
    rx_stop_ok = 1'b0;
    rx_bit     = majority({rx_samp_q[1:0], rx_line_q});
    if (!control_q[BIT_RX_ON]) begin
      rx_state_d = RX_IDLE;
    end else if (bt.tick) begin
      rx_phase_d = rx_phase_q + 4'h1;
      if (rx_phase_q == SAMPLE_A || rx_phase_q == SAMPLE_B) begin
        rx_samp_d = {rx_samp_q[1:0], rx_line_q};
      end
      unique case (rx_state_q)
        RX_IDLE: begin
          // A single low sample on the idle line begins start detection.
          if (!rx_line_q) begin
            rx_state_d = RX_START;
            rx_phase_d = 4'h1;
          end
        end
        RX_START: begin
          if (rx_phase_q == SAMPLE_C) begin
            rx_state_d = rx_bit ? RX_IDLE : RX_START;
          end else if (rx_phase_q == SAMPLE_END) begin
            rx_state_d = RX_DATA;
            rx_bits_d  = 4'h0;
          end
        end
        RX_DATA: begin
          if (rx_phase_q == SAMPLE_C) begin
            if (rx_bits_q == (control_q[BIT_NINE] ? BITS_NINE : BITS_EIGHT)) begin
              rx_end     = 1'b1;
              rx_stop_ok = rx_bit;
              rx_state_d = RX_IDLE;
            end else begin
              rx_shift_d = control_q[BIT_NINE] ? {rx_bit, rx_shift_q[8:1]}
                                              : {1'b0, rx_bit, rx_shift_q[7:1]};
              rx_bits_d  = rx_bits_q + 4'h1;
            end
          end
        end
        default: rx_state_d = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rx_state_q <= RX_IDLE;
      rx_phase_q <= 4'h0;
      rx_samp_q  <= 3'h7;
      rx_bits_q  <= 4'h0;
      rx_shift_q <= 9'h000;
    end else if (I_CLK_EN) begin
      rx_state_q <= rx_state_d;
      rx_phase_q <= rx_phase_d;
      rx_samp_q  <= rx_samp_d;
      rx_bits_q  <= rx_bits_d;
      rx_shift_q <= rx_shift_d;
    end
  end

  //----------------------------------------------------------------------------
  // Registers and flags
  //----------------------------------------------------------------------------
  always_comb begin
    control_d              = control_q;
    divisor_d              = divisor_q;
    tx_hold_d              = tx_hold_q;
    tx_pending_d           = tx_pending_q;
    rx_data_d              = rx_data_q;
    rx_done_flag_d         = rx_done_flag_q;
    tx_done_flag_d         = tx_done_flag_q;
    tx_buffer_empty_flag_d = tx_buffer_empty_flag_q;
    framing_error_flag_d   = framing_error_flag_q;
    overrun_flag_d         = overrun_flag_q;
    overrun_hidden_d       = overrun_hidden_q;
    rdata_d                = 8'h00;
    if (wr_control) begin
      control_d = {I_WDATA[7:2], control_q[BIT_RX_NINTH], I_WDATA[BIT_TX_NINTH]};
    end
    if (I_WR && I_ADDR == ADDR_DIVISOR) begin
      divisor_d = I_WDATA;
    end
    if (rd_data) begin
      rx_done_flag_d = 1'b0;
      if (overrun_hidden_q) begin
        overrun_flag_d   = 1'b1;
        overrun_hidden_d = 1'b0;
      end
    end
    if (tx_load) begin
      tx_pending_d           = 1'b0;
      tx_buffer_empty_flag_d = 1'b1;
    end
    if (wr_data) begin
      tx_hold_d              = I_WDATA;
      tx_pending_d           = 1'b1;
      tx_buffer_empty_flag_d = 1'b0;
    end
    if ((wr_status && I_WDATA[BIT_TX_DONE]) || I_TX_DONE_ACK) begin
      tx_done_flag_d = 1'b0;
    end
    if (tx_finish) begin
      tx_done_flag_d = 1'b1;
    end
    if (rx_end) begin
      if (rx_done_flag_q && !rd_data) begin
        overrun_hidden_d = 1'b1;
      end else begin
        rx_data_d            = rx_shift_q[7:0];
        control_d[BIT_RX_NINTH] = rx_shift_q[8];
        rx_done_flag_d       = 1'b1;
        framing_error_flag_d = !rx_stop_ok;
        overrun_flag_d       = 1'b0;
      end
    end
    if (I_RD) begin
      unique case (I_ADDR)
        ADDR_DATA: rdata_d = rx_data_q;
        ADDR_STATUS: rdata_d = {rx_done_flag_q, tx_done_flag_q, tx_buffer_empty_flag_q,
                                framing_error_flag_q, overrun_flag_q, 3'h0};
        ADDR_CONTROL: rdata_d = {control_q[7:1], 1'b0};
        ADDR_DIVISOR: rdata_d = divisor_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      control_q              <= CONTROL_RESET;
      divisor_q              <= 8'h00;
      tx_hold_q              <= 8'h00;
      tx_pending_q           <= 1'b0;
      rx_data_q              <= 8'h00;
      rx_done_flag_q         <= STATUS_RESET[BIT_RX_DONE];
      tx_done_flag_q         <= STATUS_RESET[BIT_TX_DONE];
      tx_buffer_empty_flag_q <= STATUS_RESET[BIT_TX_EMPTY];
      framing_error_flag_q   <= STATUS_RESET[BIT_FRAME_ERR];
      overrun_flag_q         <= STATUS_RESET[BIT_OVERRUN];
      overrun_hidden_q       <= 1'b0;
      O_RDATA                <= 8'h00;
      O_RX_DONE_IRQ          <= 1'b0;
      O_TX_DONE_IRQ          <= 1'b0;
      O_TX_EMPTY_IRQ         <= 1'b0;
    end else if (I_CLK_EN) begin
      control_q              <= control_d;
      divisor_q              <= divisor_d;
      tx_hold_q              <= tx_hold_d;
      tx_pending_q           <= tx_pending_d;
      rx_data_q              <= rx_data_d;
      rx_done_flag_q         <= rx_done_flag_d;
      tx_done_flag_q         <= tx_done_flag_d;
      tx_buffer_empty_flag_q <= tx_buffer_empty_flag_d;
      framing_error_flag_q   <= framing_error_flag_d;
      overrun_flag_q         <= overrun_flag_d;
      overrun_hidden_q       <= overrun_hidden_d;
      O_RDATA                <= rdata_d;
      O_RX_DONE_IRQ          <= rx_done_flag_d && control_d[BIT_RX_IE];
      O_TX_DONE_IRQ          <= tx_done_flag_d && control_d[BIT_TX_IE];
      O_TX_EMPTY_IRQ         <= tx_buffer_empty_flag_d && control_d[BIT_EMPTY_IE];
    end
  end

endmodule : serial_port

// ### serial_port_assertions.sv
// Concurrent checks on the ports of the serial port.
`timescale 1ns/1ps
module serial_port_checker
  import serial_port_pkg::*;
(
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_NRST,
  input  wire logic       I_CLK_EN,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic       I_TX_DONE_ACK,
  input  wire logic       I_RXD,
  input  wire logic [7:0] O_RDATA,
  input  wire logic       O_TXD,
  input  wire logic       O_TXD_OE,
  input  wire logic       O_RX_DONE_IRQ,
  input  wire logic       O_TX_DONE_IRQ,
  input  wire logic       O_TX_EMPTY_IRQ
);
  wire rd_ok = I_CLK_EN & I_RD;
  wire wr_ok = I_CLK_EN & I_WR;
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_NRST);
  property p_reset_idle; $rose(I_NRST) |-> O_TXD && !O_TXD_OE && O_RDATA == 8'h00; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_rdata_idle; (I_CLK_EN && !I_RD) |=> O_RDATA == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero without read");
  property p_unmapped; (rd_ok && I_ADDR == 8'h00) |=> O_RDATA == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_resv; (rd_ok && I_ADDR == ADDR_STATUS) |=> O_RDATA[2:0] == 3'h0; endproperty
  a_status_resv: assert property (p_status_resv) else $error("status low bits not zero");
  property p_ctrl_wo; (rd_ok && I_ADDR == ADDR_CONTROL) |=> O_RDATA[BIT_TX_NINTH] == 1'b0; endproperty
  a_ctrl_wo: assert property (p_ctrl_wo) else $error("write-only ninth bit read back");
  property p_empty_clr; (wr_ok && I_ADDR == ADDR_DATA) |=> !O_TX_EMPTY_IRQ; endproperty
  a_empty_clr: assert property (p_empty_clr) else $error("empty request after data write");
  property p_empty_lvl;
    (O_TX_EMPTY_IRQ && !(I_WR && (I_ADDR == ADDR_DATA || I_ADDR == ADDR_CONTROL))) |=> O_TX_EMPTY_IRQ;
  endproperty
  a_empty_lvl: assert property (p_empty_lvl) else $error("empty request dropped");
  property p_ack_clr; (I_CLK_EN && I_TX_DONE_ACK) |=> !O_TX_DONE_IRQ; endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("tx done kept after ack");
  property p_w1c; (wr_ok && I_ADDR == ADDR_STATUS && I_WDATA[BIT_TX_DONE]) |=> !O_TX_DONE_IRQ; endproperty
  a_w1c: assert property (p_w1c) else $error("tx done kept after write one");
  property p_rx_clr; (rd_ok && I_ADDR == ADDR_DATA) |=> !O_RX_DONE_IRQ; endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx done kept after data read");
  property p_oe; !O_TXD |-> O_TXD_OE; endproperty
  a_oe: assert property (p_oe) else $error("line low while not driven");
endmodule : serial_port_checker

bind serial_port serial_port_checker u_checker (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_CLK_EN(I_CLK_EN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .I_TX_DONE_ACK(I_TX_DONE_ACK), .I_RXD(I_RXD), .O_RDATA(O_RDATA),
  .O_TXD(O_TXD), .O_TXD_OE(O_TXD_OE), .O_RX_DONE_IRQ(O_RX_DONE_IRQ), .O_TX_DONE_IRQ(O_TX_DONE_IRQ),
  .O_TX_EMPTY_IRQ(O_TX_EMPTY_IRQ)
);

// ### serial_node.sv
// Remote serial node: sends frames to the port and captures the frames it sends.
`timescale 1ns/1ps
module serial_node #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic i_clk,
  input  wire logic i_nine,
  input  wire logic i_line,
  output logic      o_line
);
  logic [8:0] got_word;
  logic [8:0] shift_w;
  logic       stop_ok;
  int         n_got;
  initial begin
    o_line   = 1'b1;
    n_got    = 0;
    got_word = 9'h000;
    stop_ok  = 1'b0;
  end
  task automatic send(input logic [8:0] w, input logic stop_lvl);
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_clk);
    for (int i = 0; i < (i_nine ? 9 : 8); i++) begin
      o_line <= w[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_line <= stop_lvl;
    repeat (BIT_CLKS) @(posedge i_clk);
    o_line <= 1'b1;
  endtask : send
  // Samples each bit of the port's frames at its middle.
  always begin
    @(negedge i_line);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    if (i_line === 1'b0) begin
      shift_w = 9'h000;
      for (int i = 0; i < (i_nine ? 9 : 8); i++) begin
        repeat (BIT_CLKS) @(posedge i_clk);
        shift_w[i] = i_line;
      end
      repeat (BIT_CLKS) @(posedge i_clk);
      stop_ok  = i_line;
      got_word = shift_w;
      n_got++;
    end
  end
endmodule : serial_node

// ### serial_port_bench.sv
// Self-checking bench for the serial port with a remote node on its line.
`timescale 1ns/1ps
module serial_port_bench
  import serial_port_pkg::*;
;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       rd = 1'b0;
  logic       wr = 1'b0;
  logic       ack = 1'b0;
  logic       en = 1'b1;
  logic       nine = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       rxd;
  logic [7:0] rdata;
  logic       txd;
  logic       txd_oe;
  logic       rx_irq;
  logic       tx_irq;
  logic       empty_irq;
  int         n_errors = 0;
  int         num_checks = 0;

  always #4 clk = ~clk;

  serial_port dut (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_CLK_EN(en), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_TX_DONE_ACK(ack), .I_RXD(rxd), .O_RDATA(rdata), .O_TXD(txd), .O_TXD_OE(txd_oe),
    .O_RX_DONE_IRQ(rx_irq), .O_TX_DONE_IRQ(tx_irq), .O_TX_EMPTY_IRQ(empty_irq)
  );
  serial_node #(.BIT_CLKS(32)) node (.i_clk(clk), .i_nine(nine), .i_line(txd), .o_line(rxd));

  // ------------------------------------------------------------------
  // Bus and comparison helpers
  // ------------------------------------------------------------------
  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("read of %h", a), {1'b0, exp}, {1'b0, rdata});
  endtask : rd_reg
  task automatic wait_tx(input int n);
    for (int i = 0; i < 4000 && node.n_got < n; i++) @(posedge clk);
    chk("frame count", 9'(n), 9'(node.n_got));
  endtask : wait_tx

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    rd_reg(ADDR_STATUS, STATUS_RESET);
    rd_reg(ADDR_CONTROL, CONTROL_RESET);
    rd_reg(8'h00, 8'h00);
    wr_reg(ADDR_DIVISOR, 8'h01);
    rd_reg(ADDR_DIVISOR, 8'h01);
    // A write while the clock enable is low must leave the divisor untouched.
    @(posedge clk);
    en <= 1'b0;
    wr_reg(ADDR_DIVISOR, 8'h07);
    en <= 1'b1;
    rd_reg(ADDR_DIVISOR, 8'h01);
    wr_reg(ADDR_CONTROL, 8'h39);
    rd_reg(ADDR_CONTROL, 8'h3A);
    chk("empty irq", 9'h001, 9'(empty_irq));
  endtask : t_regs
  task automatic t_tx();
    wr_reg(ADDR_DATA, 8'hA5);
    cyc(3);
    wr_reg(ADDR_DATA, 8'h3C);
    cyc(2);
    rd_reg(ADDR_STATUS, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h30);
    cyc(2);
    #1 chk("txd oe", 9'h001, 9'(txd_oe));
    wait_tx(1);
    chk("tx word", 9'h0A5, node.got_word);
    wait_tx(2);
    chk("tx word", 9'h03C, node.got_word);
    chk("tx stop", 9'h001, 9'(node.stop_ok));
    cyc(24);
    rd_reg(ADDR_STATUS, 8'h60);
    chk("txd oe", 9'h000, 9'(txd_oe));
    wr_reg(ADDR_STATUS, 8'h40);
    rd_reg(ADDR_STATUS, 8'h20);
  endtask : t_tx
  task automatic t_rx();
    wr_reg(ADDR_CONTROL, 8'h90);
    node.send(9'h096, 1'b1);
    cyc(4);
    rd_reg(ADDR_STATUS, 8'hA0);
    chk("rx irq", 9'h001, 9'(rx_irq));
    rd_reg(ADDR_DATA, 8'h96);
    rd_reg(ADDR_STATUS, 8'h20);
    node.send(9'h0C3, 1'b0);
    cyc(4);
    rd_reg(ADDR_STATUS, 8'hB0);
    rd_reg(ADDR_DATA, 8'hC3);
    cyc(40);
    node.send(9'h05A, 1'b1);
    cyc(4);
    rd_reg(ADDR_STATUS, 8'hA0);
    rd_reg(ADDR_DATA, 8'h5A);
  endtask : t_rx
  task automatic t_overrun();
    node.send(9'h011, 1'b1);
    node.send(9'h022, 1'b1);
    cyc(4);
    rd_reg(ADDR_STATUS, 8'hA0);
    rd_reg(ADDR_DATA, 8'h11);
    rd_reg(ADDR_STATUS, 8'h28);
    node.send(9'h033, 1'b1);
    cyc(4);
    rd_reg(ADDR_STATUS, 8'hA0);
    wr_reg(ADDR_CONTROL, 8'h80);
    rd_reg(ADDR_STATUS, 8'hA0);
    node.send(9'h044, 1'b1);
    cyc(4);
    rd_reg(ADDR_DATA, 8'h33);
    rd_reg(ADDR_STATUS, 8'h20);
    chk("rx irq", 9'h000, 9'(rx_irq));
  endtask : t_overrun
  task automatic t_nine();
    nine <= 1'b1;
    wr_reg(ADDR_CONTROL, 8'h5D);
    wr_reg(ADDR_DATA, 8'h0F);
    wait_tx(3);
    chk("tx word", 9'h10F, node.got_word);
    cyc(24);
    chk("tx done irq", 9'h001, 9'(tx_irq));
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1 chk("tx done irq", 9'h000, 9'(tx_irq));
    node.send(9'h1AA, 1'b1);
    cyc(4);
    rd_reg(ADDR_CONTROL, 8'h5E);
    rd_reg(ADDR_DATA, 8'hAA);
  endtask : t_nine

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_overrun();
    t_nine();
    conclude();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule : serial_port_bench
